// ### stepper_translator.sv
// Translator and chopper current control for a two-phase bipolar bridge
// ==========================================================
// Behaviour
// - Full step gives two quadrature phase signals
// - Direction input selects which phase leads
// - Each step pulse advances exactly one step
// - Half step gives four signals plus inhibits
// - Half step moves half angle per pulse
// - Home input forces sequence start position
// - Mode input selects full or half step
// - Inhibit input tri-states all bridge drives
// - Oscillator period start resets both latches
// - Latches combine with translator into six signals
// - Comparator sets latch, shorts winding equiphase
// - Latch reset restores diagonal conduction
// - One oscillator times both phase regulators
// - Blanking holds latches reset, ignores comparators
// - Blanking length is configurable
// - Host selects one of four current levels
// - Host uses half step only near resonance in auto mode
// - Host may boost current in half positions
// - Host never parks boosted in half position
// - Unpowered phase in half step is tri-stated
// - Full step keeps both phase inhibits high
`timescale 1ns/1ps
module stepper_translator #(
	parameter int CHOP_PERIOD = stepper_pkg::CHOP_CYC
) (
	input  wire logic                            MCLK,
	input  wire logic                            RST,
	stepper_if.dev                               link,
	input  wire logic [1:0]                      SENSE,
	input  wire logic [stepper_pkg::BLANK_W-1:0] BLANK_LEN,
	output logic                                 IN_A,
	output logic                                 IN_B,
	output logic                                 IN_C,
	output logic                                 IN_D,
	output logic                                 INH1_N,
	output logic                                 INH2_N,
	output logic [1:0]                           VREF_SEL
);
	import stepper_pkg::*;

	logic             step_prev_q;
	logic             step_prev_d;
	logic [POS_W-1:0] pos_q;
	logic [POS_W-1:0] pos_d;
	logic [1:0]       latch_q;
	logic [1:0]       latch_d;
	logic [1:0]       hi_q;
	logic [1:0]       hi_d;
	logic [1:0]       lo_q;
	logic [1:0]       lo_d;
	logic [1:0]       inh_n_q;
	logic [1:0]       inh_n_d;
	logic [1:0]       off_q;
	logic [1:0]       off_d;
	logic [1:0]       vref_q;
	logic [1:0]       vref_d;
	logic             chop_start;
	logic             chop_blank;
	logic             step_edge;

	// ==========================================================
	// Chopping oscillator
	chop_osc #(
		.PERIOD    (CHOP_PERIOD)
	) u_osc (
		.clk       (MCLK),
		.rst       (RST),
		.blank_len (BLANK_LEN),
		.start     (chop_start),
		.blank     (chop_blank)
	);

	// ==========================================================
	// Translator position
	assign step_edge = link.step && !step_prev_q;

	always_comb begin
		step_prev_d = link.step;
		pos_d       = pos_q;
		if (link.home) begin
			pos_d = HOME_POS;
		end else if (step_edge) begin
			if (link.half) begin
				if (link.dir) begin
					pos_d = pos_q + 3'h1;
				end else begin
					pos_d = pos_q - 3'h1;
				end
			end else begin
				// Full step lands on even positions: both windings always powered
				if (link.dir) begin
					pos_d = {pos_q[2:1] + 2'h1, 1'b0};
				end else if (pos_q[0]) begin
					pos_d = {pos_q[2:1], 1'b0};
				end else begin
					pos_d = {pos_q[2:1] - 2'h1, 1'b0};
				end
			end
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			step_prev_q <= 1'b0;
			pos_q       <= HOME_POS;
		end else begin
			step_prev_q <= step_prev_d;
			pos_q       <= pos_d;
		end
	end

	// ==========================================================
	// Per-phase chopper latch and bridge drive
	for (genvar i = 0; i < 2; i++) begin : g_phase
		logic on;
		logic fwd;

		assign on  = ON_MASK[i][pos_q];
		assign fwd = POS_MASK[i][pos_q];

		always_comb begin
			// Comparator ignored while blanked, so diode recovery spikes never trip it
			if (chop_start) begin
				latch_d[i] = 1'b0;
			end else if (chop_blank) begin
				latch_d[i] = 1'b0;
			end else if (SENSE[i]) begin
				latch_d[i] = 1'b1;
			end else begin
				latch_d[i] = latch_q[i];
			end
			off_d[i] = !on;
			if (link.inhibit) begin
				hi_d[i]    = 1'b0;
				lo_d[i]    = 1'b0;
				inh_n_d[i] = 1'b0;
			end else if (!on && link.half) begin
				hi_d[i]    = 1'b0;
				lo_d[i]    = 1'b0;
				inh_n_d[i] = 1'b0;
			end else if (latch_q[i] || !on) begin
				hi_d[i]    = 1'b0;
				lo_d[i]    = 1'b0;
				inh_n_d[i] = 1'b1;
			end else begin
				hi_d[i]    = fwd;
				lo_d[i]    = !fwd;
				inh_n_d[i] = 1'b1;
			end
		end
	end

	// ==========================================================
	// Chopper latches
	// Latch clears on the period start cycle, which the blank window always covers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			latch_q <= 2'h0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// ==========================================================
	// Bridge drive registers
	// Reset leaves both bridges tri-stated until the first edge after release
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			hi_q    <= 2'h0;
			lo_q    <= 2'h0;
			inh_n_q <= 2'h0;
			off_q   <= 2'h0;
		end else begin
			hi_q    <= hi_d;
			lo_q    <= lo_d;
			inh_n_q <= inh_n_d;
			off_q   <= off_d;
		end
	end

	// ==========================================================
	// Current level
	// Registered so the reference moves in step with the bridge drive
	always_comb begin
		vref_d = link.cur_sel;
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			vref_q <= 2'h0;
		end else begin
			vref_q <= vref_d;
		end
	end

	// ==========================================================
	// Outputs
	assign IN_A          = hi_q[0];
	assign IN_B          = lo_q[0];
	assign IN_C          = hi_q[1];
	assign IN_D          = lo_q[1];
	assign INH1_N        = inh_n_q[0];
	assign INH2_N        = inh_n_q[1];
	assign VREF_SEL      = vref_q;
	assign link.half_pos = off_q;
endmodule : stepper_translator

// ### stepper_pkg.sv
// Shared constants and types for the stepper translator and its host controller
package stepper_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CHOP_PERIOD_NS = 50000;
	localparam int CHOP_CYC       = CHOP_PERIOD_NS / CLK_PERIOD_NS;
	localparam int BLANK_NS       = 1000;
	localparam int BLANK_CYC      = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_HI_NS     = 2000;
	localparam int STEP_HI_CYC    = (STEP_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLANK_W        = 12;

	// ==========================================================
	// Translator sequence, one bit per position
	localparam int         POS_W    = 3;
	localparam logic [2:0] HOME_POS = 3'h0;
	localparam logic [7:0] ON_MASK  [2] = '{8'h77, 8'hDD};
	localparam logic [7:0] POS_MASK [2] = '{8'h07, 8'hC1};

	// ==========================================================
	// Host register map
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_PERIOD = 4'h4;
	localparam logic [3:0] REG_COUNT  = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int CTRL_DIR   = 0;
	localparam int CTRL_HALF  = 1;
	localparam int CTRL_HOME  = 2;
	localparam int CTRL_INH   = 3;
	localparam int CTRL_CUR   = 4;
	localparam int CTRL_BOOST = 6;
	localparam int CTRL_AUTO  = 7;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [15:0] PERIOD_RESET = 16'h03E8;
	localparam logic [15:0] RES_LO_DEF   = 16'h0200;
	localparam logic [15:0] RES_HI_DEF   = 16'h0800;
	localparam logic [1:0]  CUR_MAX      = 2'h3;

	typedef enum logic [1:0] {
		PULSE_IDLE = 2'b00,
		PULSE_HIGH = 2'b01,
		PULSE_LOW  = 2'b10
	} pulse_state_type;

endpackage : stepper_pkg

// ### stepper_if.sv
// Link between the host step controller and the translator
`timescale 1ns/1ps
interface stepper_if;
	logic       step;
	logic       dir;
	logic       home;
	logic       half;
	logic       inhibit;
	logic [1:0] cur_sel;
	logic [1:0] half_pos;

	modport dev (input step, dir, home, half, inhibit, cur_sel, output half_pos);
	modport host (output step, dir, home, half, inhibit, cur_sel, input half_pos);
endinterface : stepper_if

// ### chop_osc.sv
// Shared chopping oscillator with blanking window
`timescale 1ns/1ps
module chop_osc #(
	parameter int PERIOD = stepper_pkg::CHOP_CYC
) (
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic [stepper_pkg::BLANK_W-1:0] blank_len,
	output logic                                 start,
	output logic                                 blank
);
	import stepper_pkg::*;

	localparam int CW = $clog2(PERIOD);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// ==========================================================
	// Period counter
	always_comb begin
		cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Window always covers the start cycle, even with a zero length
	assign start = (cnt_q == '0);
	assign blank = start || ({{(32-CW){1'b0}}, cnt_q} < {{(32-BLANK_W){1'b0}}, blank_len});
endmodule : chop_osc

// ### stepper_host.sv
// Host step controller: register port in, step commands out on the link
`timescale 1ns/1ps
module stepper_host #(
	parameter logic [15:0] RES_LO = stepper_pkg::RES_LO_DEF,
	parameter logic [15:0] RES_HI = stepper_pkg::RES_HI_DEF
) (
	input  wire logic        MCLK,
	input  wire logic        RST,
	stepper_if.host          link,
	input  wire logic [3:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic [31:0]      RDATA
);
	import stepper_pkg::*;

	localparam logic [15:0] HI_LAST = 16'(STEP_HI_CYC - 1);

	pulse_state_type state_q;
	pulse_state_type state_d;
	logic [7:0]      ctrl_q;
	logic [7:0]      ctrl_d;
	logic [15:0]     period_q;
	logic [15:0]     period_d;
	logic [16:0]     remain_q;
	logic [16:0]     remain_d;
	logic [15:0]     timer_q;
	logic [15:0]     timer_d;
	logic            step_q;
	logic            step_d;
	logic            half_q;
	logic            half_d;
	logic [1:0]      cur_q;
	logic [1:0]      cur_d;
	logic [31:0]     rdata_q;
	logic [31:0]     rdata_d;
	logic            in_res;
	logic            busy;

	// ==========================================================
	// Mode and current choice
	assign in_res = (period_q >= RES_LO) && (period_q <= RES_HI);
	assign busy   = (state_q != PULSE_IDLE) || (remain_q != 17'h0);

	// ==========================================================
	// Registers and pulse sequencer
	always_comb begin
		ctrl_d   = ctrl_q;
		period_d = period_q;
		remain_d = remain_q;
		timer_d  = timer_q;
		state_d  = state_q;
		step_d   = step_q;
		rdata_d  = 32'h0;
		// Mode only changes between pulses so a step never splits
		half_d   = half_q;
		if (state_q == PULSE_IDLE) begin
			half_d = ctrl_q[CTRL_AUTO] ? in_res : ctrl_q[CTRL_HALF];
		end
		cur_d = ctrl_q[CTRL_CUR +: 2];
		if (ctrl_q[CTRL_BOOST] && busy && (link.half_pos != 2'h0)) begin
			cur_d = CUR_MAX;
		end
		case (state_q)
			PULSE_IDLE: begin
				if ((remain_q != 17'h0) && !ctrl_q[CTRL_HOME] && !ctrl_q[CTRL_INH]) begin
					state_d = PULSE_HIGH;
					step_d  = 1'b1;
					timer_d = 16'h0;
				end
			end
			PULSE_HIGH: begin
				timer_d = timer_q + 16'h1;
				if (timer_q >= HI_LAST) begin
					state_d = PULSE_LOW;
					step_d  = 1'b0;
				end
			end
			PULSE_LOW: begin
				timer_d = timer_q + 16'h1;
				if (timer_q >= period_q - 16'h1) begin
					state_d  = PULSE_IDLE;
					remain_d = remain_q - 17'h1;
				end
			end
			default: begin
				state_d = PULSE_IDLE;
				step_d  = 1'b0;
			end
		endcase
		if (WR) begin
			case (ADDR)
				REG_CTRL:   ctrl_d   = WDATA[7:0];
				REG_PERIOD: period_d = WDATA[15:0];
				// Count is in full steps; half step needs two pulses each
				REG_COUNT:  remain_d = half_d ? {WDATA[15:0], 1'b0} : {1'b0, WDATA[15:0]};
				default:    ;
			endcase
		end
		if (RD) begin
			case (ADDR)
				REG_CTRL:   rdata_d = {24'h0, ctrl_q};
				REG_PERIOD: rdata_d = {16'h0, period_q};
				REG_COUNT:  rdata_d = {15'h0, remain_q};
				REG_STATUS: rdata_d = {28'h0, link.half_pos, half_q, busy};
				default:    rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_q  <= PULSE_IDLE;
			ctrl_q   <= CTRL_RESET;
			period_q <= PERIOD_RESET;
			remain_q <= 17'h0;
			timer_q  <= 16'h0;
			step_q   <= 1'b0;
			half_q   <= 1'b0;
			cur_q    <= 2'h0;
			rdata_q  <= 32'h0;
		end else begin
			state_q  <= state_d;
			ctrl_q   <= ctrl_d;
			period_q <= period_d;
			remain_q <= remain_d;
			timer_q  <= timer_d;
			step_q   <= step_d;
			half_q   <= half_d;
			cur_q    <= cur_d;
			rdata_q  <= rdata_d;
		end
	end

	// ==========================================================
	// Outputs
	assign link.step    = step_q;
	assign link.dir     = ctrl_q[CTRL_DIR];
	assign link.home    = ctrl_q[CTRL_HOME];
	assign link.inhibit = ctrl_q[CTRL_INH];
	assign link.half    = half_q;
	assign link.cur_sel = cur_q;
	assign RDATA        = rdata_q;
endmodule : stepper_host

// ### stepper_chk.sv
// Assertion checker for the stepper link and bridge drive
`timescale 1ns/1ps
module stepper_chk (
	input wire logic       MCLK,
	input wire logic       RST,
	input wire logic       step,
	input wire logic       home,
	input wire logic       half,
	input wire logic       inhibit,
	input wire logic [1:0] cur_sel,
	input wire logic [1:0] half_pos,
	input wire logic       IN_A,
	input wire logic       IN_B,
	input wire logic       IN_C,
	input wire logic       IN_D,
	input wire logic       INH1_N,
	input wire logic       INH2_N,
	input wire logic [1:0] VREF_SEL
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	sequence s_home;
		home [*3];
	endsequence
	sequence s_hrise;
		$rose(step) && half && !home;
	endsequence
	property p_inh;
		inhibit |=> !(IN_A || IN_B || IN_C || IN_D || INH1_N || INH2_N);
	endproperty
	a_inh: assert property (p_inh) else $error("drive not off under inhibit");
	// Drive lags reset release by one edge, so the release edge is no trigger
	property p_full_en;
		!RST && !half && !inhibit |=> INH1_N && INH2_N;
	endproperty
	a_full_en: assert property (p_full_en) else $error("phase off in full step");
	property p_vref;
		1'b1 |=> VREF_SEL == $past(cur_sel);
	endproperty
	a_vref: assert property (p_vref) else $error("current level not passed on");
	property p_off;
		(!INH1_N |-> !IN_A && !IN_B) and (!INH2_N |-> !IN_C && !IN_D);
	endproperty
	a_off: assert property (p_off) else $error("tri-stated phase still driven");
	property p_pair;
		!(IN_A && IN_B) && !(IN_C && IN_D);
	endproperty
	a_pair: assert property (p_pair) else $error("bridge pair both high");
	property p_home;
		s_home |=> half_pos == 2'h0;
	endproperty
	a_home: assert property (p_home) else $error("home not at start position");
	property p_step_hi;
		$rose(step) |=> step [*8];
	endproperty
	a_step_hi: assert property (p_step_hi) else $error("step pulse too short");
	property p_half_out;
		s_hrise ##0 half_pos == 2'h0 |-> ##[1:4] half_pos != 2'h0;
	endproperty
	a_half_out: assert property (p_half_out) else $error("half step did not halve");
	property p_half_back;
		s_hrise ##0 half_pos != 2'h0 |-> ##[1:4] half_pos == 2'h0;
	endproperty
	a_half_back: assert property (p_half_back) else $error("half step no return");
	property p_full_keep;
		$rose(step) && !half && half_pos == 2'h0 |=> half_pos == 2'h0 [*6];
	endproperty
	a_full_keep: assert property (p_full_keep) else $error("full step hit half");
endmodule : stepper_chk

// ### stepper_translator_chopper_bench.sv
// Self-checking bench: host controller driving the translator over the link
`timescale 1ns/1ps
module stepper_translator_chopper_bench;
	import stepper_pkg::*;
	// ==========================================================
	// Wiring
	typedef struct packed {
		logic [3:0]  a;
		logic [31:0] w;
		logic [31:0] e;
	} row_type;
	localparam int CP = 50;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic [1:0]  sense = 2'h0;
	logic [11:0] blank = 12'h005;
	logic [31:0] rdata;
	logic        in_a, in_b, in_c, in_d, inh1_n, inh2_n;
	logic [1:0]  vref;
	logic [5:0]  drv;
	logic [31:0] got;
	int          num_errors = 0;
	int          samples_checked = 0;
	row_type     rows [5] = '{'{REG_CTRL, 32'h35, 32'h35}, '{REG_CTRL, 32'h0A, 32'h0A},
		'{4'h2, 32'hFF, 32'h0}, '{REG_PERIOD, 32'h12C, 32'h12C}, '{REG_CTRL, 32'h0, 32'h0}};
	// Index 0 walks down, 1 walks up, both from the start position
	logic [5:0]  full_tab [2][4] = '{'{6'h1B, 6'h17, 6'h27, 6'h2B}, '{6'h27, 6'h17, 6'h1B, 6'h2B}};
	assign drv = {in_a, in_b, in_c, in_d, inh1_n, inh2_n};
	always #5 mclk = ~mclk;
	stepper_if lnk ();
	stepper_translator #(.CHOP_PERIOD(CP)) u_stepper_translator (.MCLK(mclk), .RST(rst),
		.link(lnk.dev), .SENSE(sense), .BLANK_LEN(blank), .IN_A(in_a), .IN_B(in_b),
		.IN_C(in_c), .IN_D(in_d), .INH1_N(inh1_n), .INH2_N(inh2_n), .VREF_SEL(vref));
	stepper_host u_stepper_host (.MCLK(mclk), .RST(rst), .link(lnk.host), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata));
	stepper_chk u_stepper_chk (.MCLK(mclk), .RST(rst), .step(lnk.step), .home(lnk.home),
		.half(lnk.half), .inhibit(lnk.inhibit), .cur_sel(lnk.cur_sel), .half_pos(lnk.half_pos),
		.IN_A(in_a), .IN_B(in_b), .IN_C(in_c), .IN_D(in_d), .INH1_N(inh1_n), .INH2_N(inh2_n),
		.VREF_SEL(vref));
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		#1 got = rdata;
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	// Bounded poll: a stuck busy flag is counted, never waited out
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			rd(REG_STATUS);
			k++;
		end while (got[0] !== 1'b0 && k < 3000);
		if (got[0] !== 1'b0) begin
			num_errors++;
			$display("[FAIL] t=%0t busy=%h exp=%h", $time, got[0], 1'b0);
		end
	endtask : wait_idle
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// Watchdog
	initial begin
		repeat (60000) @(posedge mclk);
		num_errors++;
		$display("[FAIL] t=%0t watchdog=%h exp=%h", $time, 1'b1, 1'b0);
		tally_and_finish();
	end
	// ==========================================================
	// Tests
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		settle(3);
		chk(32'(drv), 32'h2B);
		rd(REG_PERIOD);
		chk(got, 32'(PERIOD_RESET));
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			chk(got, rows[i].e);
		end
		$display("register rows done");
		for (int d = 1; d >= 0; d--) for (int i = 0; i < 4; i++) begin
			wr(REG_CTRL, 32'(d));
			wr(REG_COUNT, 32'h1);
			wait_idle();
			settle(3);
			chk(32'(drv), 32'(full_tab[d][i]));
		end
		$display("full step test done");
		wr(REG_PERIOD, 32'h3E8);
		wr(REG_CTRL, 32'h3);
		wr(REG_COUNT, 32'h1);
		settle(400);
		chk(32'(drv), 32'h22);
		rd(REG_STATUS);
		chk(got, 32'hB);
		wait_idle();
		settle(3);
		chk(32'(drv), 32'h27);
		$display("half step test done");
		wr(REG_CTRL, 32'h53);
		wr(REG_COUNT, 32'h1);
		settle(400);
		chk(32'(drv), 32'h05);
		chk(32'(vref), 32'h3);
		wait_idle();
		settle(3);
		chk(32'(vref), 32'h1);
		$display("boost test done");
		wr(REG_CTRL, 32'h8);
		settle(4);
		chk(32'(drv), 32'h0);
		wr(REG_CTRL, 32'h4);
		settle(4);
		chk(32'(drv), 32'h2B);
		for (int c = 0; c < 4; c++) begin
			wr(REG_CTRL, 32'(c) << 4);
			settle(4);
			chk(32'(vref), 32'(c));
		end
		$display("inhibit home level test done");
		wr(REG_CTRL, 32'h80);
		rd(REG_STATUS);
		chk(got, 32'h2);
		wr(REG_PERIOD, 32'h12C);
		rd(REG_STATUS);
		chk(got, 32'h0);
		$display("auto mode test done");
		for (int b = 5; b <= 20; b += 15) begin
			int ca;
			int cc;
			@(posedge mclk);
			blank <= 12'(b);
			sense <= (b == 5) ? 2'h1 : 2'h3;
			settle(2 * CP);
			ca = 0;
			cc = 0;
			repeat (CP) begin
				@(negedge mclk);
				ca += in_a;
				cc += in_c;
			end
			chk(32'(ca), 32'(b));
			chk(32'(cc), (b == 5) ? 32'(CP) : 32'(b));
		end
		@(posedge mclk);
		sense <= 2'h0;
		settle(2 * CP);
		chk(32'(drv), 32'h2B);
		$display("chopper test done");
		tally_and_finish();
	end
endmodule : stepper_translator_chopper_bench
